/* File: logic/rid_cfg.svh */
`ifndef RID_CFG_SVH
`define RID_CFG_SVH
// instruction word and field layout
`define RID_IW 12
`define RID_F_LSB 0
`define RID_F_W 5
`define RID_D_POS 5
`define RID_B_LSB 5
`define RID_B_W 3
`define RID_K8_W 8
`define RID_K9_W 9
// pin direction load targets
`define RID_PIN_DIRECTION_LOAD_A 3'h5
`define RID_PIN_DIRECTION_LOAD_B 3'h6
// oscillator periods per instruction cycle, and the pin direction reset value
`define RID_QCOUNT 4
`define RID_Q_LAST 2'h3
`define RID_PIN_DIRECTION_LOAD_RST 8'hff
`endif

/* File: logic/rid_pkg.sv */
package rid_pkg;
    typedef enum logic [2:0] {
        RID_FMT_BYTE = 3'h1,
        RID_FMT_BIT = 3'h2,
        RID_FMT_LIT = 3'h4
    } rid_fmt_t;
    typedef enum logic [1:0] {
        RID_RUN = 2'h1,
        RID_FLUSH = 2'h2
    } rid_state_t;
endpackage

/* File: logic/rid_phase_div.sv */
`timescale 1ns/1ps
`include "rid_cfg.svh"
// divides the oscillator clock into four phases and flags the last one
module rid_phase_div (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // phase outputs
    output logic [1:0] phase,
    output logic cycleEnd
);
    logic [1:0] phase_reg;
    // four oscillator periods make one instruction cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end
    assign phase = phase_reg;
    assign cycleEnd = (phase_reg == `RID_Q_LAST);
endmodule

/* File: logic/rid_decoder.sv */
`timescale 1ns/1ps
`include "rid_cfg.svh"
// Functional notes
// - program memory readout is allowed only while code protection is off.
// - each instruction is one 12-bit word of opcode plus operand fields.
// - words are sorted into byte, bit and literal/control formats.
// - byte operations pick one of 32 file registers by a 5-bit field.
// - destination bit 0 sends the result to the accumulator, 1 to the file.
// - bit operations pick a bit of the chosen 8-bit file register.
// - literal operations carry an 8-bit or 9-bit constant.
// - one cycle normally, two when a skip is taken or the pc changes.
// - one instruction cycle is four oscillator periods.
// - pc writes other than the unconditional jump clear pc bit nine.
// - pin direction load with 5 or 6 copies the accumulator to a port.
module rid_decoder
    import rid_pkg::*;
(
    // clock and reset
    clk_sys,
    rst_n,
    // instruction fetch
    instrWord,
    instrValid,
    skipTrue,
    accValue,
    // program memory verification
    codeProtect,
    verifyReq,
    verifyData,
    // decoded fields
    fmt,
    fileSel,
    destFile,
    bitSel,
    literal,
    pcWrite,
    pcBit9Clear,
    cycleStart,
    flushCycle,
    verifyOut,
    verifyValid,
    // port direction latches
    trisA,
    trisB
);
    input wire logic clk_sys;
    input wire logic rst_n;
    input wire logic [`RID_IW-1:0] instrWord;
    input wire logic instrValid;
    input wire logic skipTrue;
    input wire logic [7:0] accValue;
    input wire logic codeProtect;
    input wire logic verifyReq;
    input wire logic [`RID_IW-1:0] verifyData;
    output rid_fmt_t fmt;
    output logic [`RID_F_W-1:0] fileSel;
    output logic destFile;
    output logic [`RID_B_W-1:0] bitSel;
    output logic [`RID_K9_W-1:0] literal;
    output logic pcWrite;
    output logic pcBit9Clear;
    output logic cycleStart;
    output logic flushCycle;
    output logic [`RID_IW-1:0] verifyOut;
    output logic verifyValid;
    output logic [7:0] trisA;
    output logic [7:0] trisB;

    typedef struct packed {
        rid_state_t st;
        rid_fmt_t fmt;
        logic [`RID_F_W-1:0] fsel;
        logic dest;
        logic [`RID_B_W-1:0] bsel;
        logic [`RID_K9_W-1:0] lit;
        logic pcw;
        logic pc9c;
        logic start;
        logic flush;
        logic [`RID_IW-1:0] vout;
        logic vvalid;
        logic [7:0] trA;
        logic [7:0] trB;
    } rid_dec_t;

    rid_dec_t s_reg;
    rid_dec_t s_next;
    logic [1:0] phase;
    logic cycleEnd;

    rid_phase_div u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .phase(phase),
        .cycleEnd(cycleEnd)
    );

    // decode at the end of each instruction cycle; phase itself unused here
    always_comb begin
        logic [3:0] top;
        logic isGoto;
        logic isCall;
        logic isRetlw;
        logic pcDest;
        logic condOp;
        top = instrWord[11:8];
        isGoto = (instrWord[11:9] == 3'h5);
        isCall = (top == 4'h9);
        isRetlw = (top == 4'h8);
        // skip ops: bit tests (top 6 and 7) and decrement/increment-and-skip (bits 11:6 of 0b, 0f)
        condOp = (top == 4'h6) || (top == 4'h7)
            || (instrWord[11:6] == 6'h0b) || (instrWord[11:6] == 6'h0f);
        pcDest = 1'b0;
        s_next = s_reg;
        s_next.start = 1'b0;
        s_next.vvalid = 1'b0;
        // readout is blocked when protected; no partial data leaks
        if (verifyReq && !codeProtect) begin
            s_next.vout = verifyData;
            s_next.vvalid = 1'b1;
        end
        if (cycleEnd) begin
            case (s_reg.st)
                RID_FLUSH: begin
                    // second cycle of a branch or taken skip executes a nop
                    s_next.st = RID_RUN;
                    s_next.flush = 1'b0;
                    s_next.pcw = 1'b0;
                    s_next.pc9c = 1'b0;
                end
                default: begin
                    s_next.flush = 1'b0;
                    s_next.pcw = 1'b0;
                    s_next.pc9c = 1'b0;
                    if (instrValid) begin
                        s_next.start = 1'b1;
                        if (top[3:2] == 2'h0) begin
                            s_next.fmt = RID_FMT_BYTE;
                        end else if (top[3:2] == 2'h1) begin
                            s_next.fmt = RID_FMT_BIT;
                        end else begin
                            s_next.fmt = RID_FMT_LIT;
                        end
                        s_next.fsel = instrWord[`RID_F_W-1:0];
                        s_next.dest = instrWord[`RID_D_POS];
                        s_next.bsel = instrWord[`RID_B_LSB +: `RID_B_W];
                        // 9-bit only for the jump, else 8-bit
                        if (isGoto) begin
                            s_next.lit = instrWord[8:0];
                        end else begin
                            s_next.lit = {1'b0, instrWord[7:0]};
                        end
                        if (top[3:2] == 2'h0 && instrWord[5]
                            && instrWord[4:0] == 5'h02) begin
                            pcDest = 1'b1;
                        end
                        // clrf/movwf to pc also write it
                        if (instrWord[11:5] == 7'h03
                            || instrWord[11:5] == 7'h01) begin
                            pcDest = instrWord[4:0] == 5'h02;
                        end
                        if (isGoto || isCall || isRetlw || pcDest) begin
                            s_next.pcw = 1'b1;
                            s_next.pc9c = !isGoto;
                            s_next.st = RID_FLUSH;
                            s_next.flush = 1'b1;
                        end else if (condOp && skipTrue) begin
                            s_next.st = RID_FLUSH;
                            s_next.flush = 1'b1;
                        end
                        // bit 3 must be clear; the target sits in 2:0
                        if (instrWord[11:4] == 8'h00 && !instrWord[3]) begin
                            if (instrWord[2:0] == `RID_PIN_DIRECTION_LOAD_A) begin
                                s_next.trA = accValue;
                            end else if (instrWord[2:0] == `RID_PIN_DIRECTION_LOAD_B) begin
                                s_next.trB = accValue;
                            end
                        end
                        // x bits are never examined above
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_reg <= '{st: RID_RUN, fmt: RID_FMT_BYTE, trA: `RID_PIN_DIRECTION_LOAD_RST,
                trB: `RID_PIN_DIRECTION_LOAD_RST, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign fmt = s_reg.fmt;
    assign fileSel = s_reg.fsel;
    assign destFile = s_reg.dest;
    assign bitSel = s_reg.bsel;
    assign literal = s_reg.lit;
    assign pcWrite = s_reg.pcw;
    assign pcBit9Clear = s_reg.pc9c;
    assign cycleStart = s_reg.start;
    assign flushCycle = s_reg.flush;
    assign verifyOut = s_reg.vout;
    assign verifyValid = s_reg.vvalid;
    assign trisA = s_reg.trA;
    assign trisB = s_reg.trB;
endmodule

/* File: verification/rid_decoder_props.sv */
`timescale 1ns/1ps
module rid_decoder_props
    import rid_pkg::*;
(
    // clock, reset and fetch side
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [11:0] instrWord,
    input wire logic codeProtect,
    input wire logic verifyReq,
    input wire logic [11:0] verifyData,
    // decoded side
    input rid_fmt_t fmt,
    input wire logic [4:0] fileSel,
    input wire logic destFile,
    input wire logic [8:0] literal,
    input wire logic pcWrite,
    input wire logic pcBit9Clear,
    input wire logic cycleStart,
    input wire logic flushCycle,
    input wire logic [11:0] verifyOut,
    input wire logic verifyValid
);
    logic [11:0] wordReg;
    // word seen at the taking edge, lined up with cycleStart
    always_ff @(posedge clk_sys) wordReg <= instrWord;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence flushRun;
        flushCycle [*4] ##1 !flushCycle;
    endsequence
    start_gap_a: assert property (cycleStart |=> !cycleStart [*3])
        else $error("cycles too close");
    file_sel_a: assert property (cycleStart && wordReg[11:4] != 8'h00
        && !wordReg[11] |-> fileSel == wordReg[4:0]) else $error("fileSel");
    dest_bit_a: assert property (cycleStart && wordReg[11:10] == 2'h0
        |-> destFile == wordReg[5]) else $error("destFile");
    fmt_group_a: assert property (cycleStart && wordReg[11:10] != 2'h0
        |-> fmt == (wordReg[11] ? RID_FMT_LIT : RID_FMT_BIT))
        else $error("fmt");
    lit_field_a: assert property (cycleStart && wordReg[11]
        |-> literal[7:0] == wordReg[7:0]) else $error("literal");
    branch_flush_a: assert property (cycleStart
        && wordReg[11:10] == 2'h2 |-> pcWrite ##0 flushRun)
        else $error("branch flush");
    pc_bit9_a: assert property (cycleStart && wordReg[11:10] == 2'h2
        |-> pcBit9Clear == (wordReg[11:9] != 3'h5)) else $error("bit9");
    verify_read_a: assert property (verifyReq && !codeProtect
        |=> verifyValid && verifyOut == $past(verifyData))
        else $error("readout");
    verify_lock_a: assert property (verifyValid
        |-> $past(verifyReq) && !$past(codeProtect)) else $error("locked");
endmodule
bind rid_decoder rid_decoder_props i_props (.*);

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import rid_pkg::*;
    typedef struct packed {
        logic [11:0] w;
        logic two;
        logic pcw;
        logic [7:0] ta;
        logic [7:0] tb;
    } rid_exp_t;
    logic clk_sys = 0, rst_n = 0, instrValid = 1, skipTrue = 0;
    logic codeProtect = 1, verifyReq = 0, destFile, pcWrite, pcBit9Clear;
    logic cycleStart, flushCycle, verifyValid;
    logic [11:0] instrWord = 12'h000, verifyData = 12'h000, verifyOut, w;
    logic [7:0] accValue = 8'h00, expA = 8'hff, expB = 8'hff, trisA, trisB;
    logic [4:0] fileSel;
    logic [2:0] bitSel;
    logic [8:0] literal;
    rid_fmt_t fmt;
    rid_exp_t me;
    rid_exp_t iq[$];
    logic [11:0] vq[$];
    int fail_count = 0, checks_done = 0;
    always #20 clk_sys = ~clk_sys;
    rid_decoder i_dut (.*);
    task automatic cmp(string n, logic [11:0] e, logic [11:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // readout results pair with the oldest unprotected request
    task automatic cmp_read(logic [11:0] g);
        logic [11:0] e;
        e = 12'hxxx;
        if (vq.size() > 0) e = vq.pop_front();
        cmp("verifyOut", e, g);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // notes the expected decode, then holds the word until it is taken
    task automatic send(logic [11:0] v, logic sk);
        int n;
        logic pcw;
        logic two;
        @(posedge clk_sys);
        #1;
        accValue = 8'($urandom);
        if (v == 12'h005) expA = accValue;
        if (v == 12'h006) expB = accValue;
        // jump, call, return-literal, or a byte op that writes file 2
        pcw = v[11:9] == 3'h5 || v[11:9] == 3'h4
            || v[11:10] == 2'h0 && v[5] && v[4:0] == 5'h02;
        two = pcw || sk && (v[11:9] == 3'h3
            || v[11:6] == 6'h0b || v[11:6] == 6'h0f);
        iq.push_back('{v, two, pcw, expA, expB});
        instrWord = v;
        instrValid = 1;
        skipTrue = sk;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (cycleStart !== 1'b1 && n < 40);
        if (cycleStart !== 1'b1) begin
            fail_count++;
            test_done;
        end
    endtask
    // watcher: pairs every result with the oldest note
    always @(negedge clk_sys) begin
        if (rst_n && cycleStart === 1'b1 && iq.size() > 0) begin
            me = iq.pop_front();
            cmp("flushCycle", me.two, flushCycle);
            cmp("pcWrite", me.pcw, pcWrite);
            cmp("pcBit9Clear", me.pcw && me.w[11:9] != 3'h5,
                pcBit9Clear);
            cmp("trisA", me.ta, trisA);
            cmp("trisB", me.tb, trisB);
            if (me.w[11:4] != 8'h00) begin
                cmp("fmt", me.w[11:10] == 2'h0 ? RID_FMT_BYTE : me.w[11] ?
                    RID_FMT_LIT : RID_FMT_BIT, fmt);
                if (me.w[11]) cmp("literal", me.w[11:9] == 3'h5 ?
                    me.w[8:0] : me.w[7:0], literal);
                else cmp("fileSel", me.w[4:0], fileSel);
                if (me.w[11:10] == 2'h0)
                    cmp("destFile", me.w[5], destFile);
                if (me.w[11:10] == 2'h1) cmp("bitSel", me.w[7:5], bitSel);
            end
        end
        if (verifyValid === 1'b1) cmp_read(verifyOut);
    end
    initial begin
        void'($urandom(32'h3eed7a29));
        repeat (16) @(posedge clk_sys);
        #1 rst_n = 1;
        send(12'ha45, 0);
        send(12'h923, 0);
        send(12'h8ff, 0);
        send(12'hbff, 0);
        send(12'h005, 0);
        send(12'h006, 0);
        send(12'h7e3, 1);
        send(12'h2e4, 1);
        send(12'h3ff, 0);
        // byte op and move that land in file 2 also change the pc
        send(12'h1e2, 0);
        send(12'h022, 0);
        // no word offered: no decode may start
        @(posedge clk_sys);
        #1 instrValid = 0;
        repeat (8) begin
            @(negedge clk_sys);
            cmp("cycleStart", 12'h000, cycleStart);
        end
        repeat (60) begin
            w = 12'($urandom);
            if (w[4:0] == 5'h02) w[0] = 1'b1;
            if (w[11:4] == 8'h00) w[4] = 1'b1;
            send(w, 1'($urandom));
        end
        repeat (10) begin
            @(posedge clk_sys);
            #1;
            codeProtect = 1'($urandom);
            verifyReq = 1;
            verifyData = 12'($urandom);
            if (!codeProtect) vq.push_back(verifyData);
        end
        @(posedge clk_sys);
        #1 verifyReq = 0;
        repeat (4) @(posedge clk_sys);
        // every unprotected request must have been answered
        cmp("readQueue", 12'h000, 12'(vq.size()));
        cmp("noteQueue", 12'h000, 12'(iq.size()));
        test_done;
    end
endmodule
